// *** logic/scfm_pkg.sv ***
package scfm_pkg;
  // Number of scan chains fed by the decompressor
  localparam int NUM_CHAINS = 8;
  localparam int IDX_W = 3;
  // Register map on the plain register port
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_INDEX = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_FIFO = 4'h3;
  // Reset values
  localparam logic [IDX_W-1:0] INDEX_RST = 3'h0;
  // Mode field width and FIFO shape
  localparam int MODE_W = 2;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = 1;
  // Status field positions
  localparam int ST_EMPTY = 0;
  localparam int ST_FULL = 1;
  localparam int ST_OPT = 2;

  // Looping modes
  typedef enum logic [1:0] {
    SCFM_OFF,
    SCFM_ONE,
    SCFM_ALL,
    SCFM_MASK
  } scfm_mode_t;

  // Register-port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } scfm_req_t;

  // Chain-side drive: load data and per-chain unload enable
  typedef struct packed {
    logic [NUM_CHAINS-1:0] load;
    logic [NUM_CHAINS-1:0] unload_en;
  } scfm_chain_t;
endpackage : scfm_pkg

// *** logic/scfm_fifo.sv ***
module scfm_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  // Storage array, not reset: out_data is only used while out_valid is set
  logic [WIDTH-1:0] mem [DEPTH];

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } scfm_fifo_st_t;

  scfm_fifo_st_t st;
  scfm_fifo_st_t next_st;
  logic push;
  logic pop;

  // Honest flags straight from the count
  assign in_ready = (st.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st.cnt != '0);
  assign out_data = mem[st.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update
  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.wp = st.wp + AW'(1);
    end
    if (pop)
    begin
      next_st.rp = st.rp + AW'(1);
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Data write
  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem[st.wp] <= in_data;
    end
  end

  a_fifo_no_over: assert property (@(posedge ref_clk) disable iff (!rstn)
    st.cnt <= (AW+1)'(DEPTH)) else $error("fifo count overflow");
endmodule : scfm_fifo

// *** logic/scfm_chain_sel.sv ***
// One-hot chain selector with optional masking
module scfm_chain_sel #(
  parameter int N = 8,
  parameter int IW = 3
) (
  input wire logic [IW-1:0] index,
  input wire logic enable,
  output logic [N-1:0] onehot
);
  // Decode index to one-hot, all zero when disabled
  always_comb
  begin
    onehot = '0;
    if (enable)
    begin
      onehot[index] = 1'b1;
    end
  end
endmodule : scfm_chain_sel

// *** logic/scfm_ctrl.sv ***
// Operation
// - Single-chain mode loads and observes chosen chain
// - Unselected chains load zeros in single mode
// - Chain index resets to zero
// - Single-chain is default mode when option built
// - Broadcast drives input bit into all chains
// - Broadcast observes indexed chain when option present
// - Block-all masks load and unload with option
// - Without option broadcast observes first chain
// - Without option block-all forces channel input zero
// - Mode and index held in separate registers
// - One payload bit per packet on input
// - Without option block-all leaves output path unchanged
module scfm_ctrl #(
  parameter bit ONE_CHAIN = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic chan_in,
  input wire logic chan_in_valid,
  output logic chan_in_ready,
  input wire logic shift_en,
  input wire logic [scfm_pkg::NUM_CHAINS-1:0] decomp_in,
  input wire logic compact_out,
  input wire logic [scfm_pkg::NUM_CHAINS-1:0] chain_out,
  output logic [scfm_pkg::NUM_CHAINS-1:0] chain_load,
  output logic [scfm_pkg::NUM_CHAINS-1:0] unload_mask,
  output logic chan_out
);
  localparam int N = scfm_pkg::NUM_CHAINS;
  localparam int IW = scfm_pkg::IDX_W;

  // Whole module state
  typedef struct packed {
    scfm_pkg::scfm_mode_t mode;
    logic [IW-1:0] index;
    logic [7:0] rdata;
    logic [N-1:0] load;
    logic [N-1:0] umask;
    logic cout;
  } scfm_st_t;

  scfm_st_t st;
  scfm_st_t next_st;

  // Default mode depends on whether single-chain hardware exists
  localparam scfm_pkg::scfm_mode_t MODE_RST =
    ONE_CHAIN ? scfm_pkg::SCFM_ONE : scfm_pkg::SCFM_ALL;

  // FIFO between the streaming host and the chain feed
  logic fifo_bit;
  logic fifo_valid;
  logic fifo_pop;
  logic in_rdy;

  scfm_fifo #(
    .WIDTH(scfm_pkg::FIFO_W),
    .DEPTH(scfm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .in_data(chan_in),
    .in_valid(chan_in_valid),
    .in_ready(in_rdy),
    .out_data(fifo_bit),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // Ready reflects FIFO space; a register would lag a full cycle
  assign chan_in_ready = in_rdy;

  // One payload bit consumed per shift
  assign fifo_pop = shift_en && fifo_valid;

  // Selected chain decode; absent option forces chain zero
  logic [N-1:0] sel_oh;
  logic [IW-1:0] eff_index;
  assign eff_index = ONE_CHAIN ? st.index : '0;

  scfm_chain_sel #(
    .N(N),
    .IW(IW)
  ) u_sel (
    .index(eff_index),
    .enable(1'b1),
    .onehot(sel_oh)
  );

  // Payload bit, zero when no data is waiting
  logic pay;
  assign pay = fifo_valid ? fifo_bit : 1'b0;

  // Next-state logic: registers, chain feed and output select
  always_comb
  begin
    next_st = st;
    next_st.rdata = 8'h00;
    // Register writes
    if (reg_wr)
    begin
      if (reg_addr == scfm_pkg::ADDR_MODE)
      begin
        // Single mode ignored without the option
        if (ONE_CHAIN ||
            reg_wdata[1:0] != 2'(scfm_pkg::SCFM_ONE))
        begin
          next_st.mode = scfm_pkg::scfm_mode_t'(reg_wdata[1:0]);
        end
      end
      else if (reg_addr == scfm_pkg::ADDR_INDEX)
      begin
        next_st.index = reg_wdata[IW-1:0];
      end
    end
    // Register reads, data valid next cycle
    if (reg_rd)
    begin
      unique case (reg_addr)
        scfm_pkg::ADDR_MODE: next_st.rdata = {6'h00, st.mode};
        scfm_pkg::ADDR_INDEX: next_st.rdata = 8'({st.index});
        scfm_pkg::ADDR_STATUS:
          next_st.rdata = {5'h00, ONE_CHAIN, !in_rdy, !fifo_valid};
        scfm_pkg::ADDR_FIFO: next_st.rdata = {7'h00, fifo_valid};
        default: next_st.rdata = 8'h00;
      endcase
    end
    // Chain load and unload masking
    unique case (st.mode)
      scfm_pkg::SCFM_OFF:
      begin
        next_st.load = decomp_in;
        next_st.umask = '0;
        next_st.cout = compact_out;
      end
      scfm_pkg::SCFM_ONE:
      begin
        // Only selected chain gets payload, others zero
        next_st.load = pay ? sel_oh : '0;
        next_st.umask = ~sel_oh;
        next_st.cout = |(chain_out & sel_oh);
      end
      scfm_pkg::SCFM_ALL:
      begin
        next_st.load = {N{pay}};
        next_st.umask = ONE_CHAIN ? ~sel_oh : '0;
        // Without option eff_index is zero, so chain zero is observed
        next_st.cout = |(chain_out & sel_oh);
      end
      scfm_pkg::SCFM_MASK:
      begin
        next_st.load = '0;
        next_st.umask = ONE_CHAIN ? '1 : '0;
        next_st.cout = ONE_CHAIN ? 1'b0 : compact_out;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st.mode <= MODE_RST;
      st.index <= scfm_pkg::INDEX_RST;
      st.rdata <= 8'h00;
      st.load <= '0;
      st.umask <= '0;
      st.cout <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = st.rdata;
  assign chain_load = st.load;
  assign unload_mask = st.umask;
  assign chan_out = st.cout;

  a_single_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    st.mode == scfm_pkg::SCFM_ONE |=> (chain_load & ~$past(sel_oh)) == '0)
    else $error("unselected chain loaded");
  a_bcast_all: assert property (@(posedge ref_clk) disable iff (!rstn)
    st.mode == scfm_pkg::SCFM_ALL |=> chain_load == {N{$past(pay)}})
    else $error("broadcast mismatch");
  a_mask_load: assert property (@(posedge ref_clk) disable iff (!rstn)
    st.mode == scfm_pkg::SCFM_MASK |=> chain_load == '0)
    else $error("masked chain loaded");
  a_off_pass: assert property (@(posedge ref_clk) disable iff (!rstn)
    st.mode == scfm_pkg::SCFM_OFF |=> chain_load == $past(decomp_in)
    && chan_out == $past(compact_out))
    else $error("off mode altered path");
  a_index_write: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_wr && reg_addr == scfm_pkg::ADDR_INDEX
    |=> st.index == $past(reg_wdata[IW-1:0]))
    else $error("index write lost");
  a_obs_select: assert property (@(posedge ref_clk) disable iff (!rstn)
    ONE_CHAIN && st.mode == scfm_pkg::SCFM_ONE
    |=> chan_out == |($past(chain_out) & $past(sel_oh)))
    else $error("wrong chain observed");
  a_mask_unload: assert property (@(posedge ref_clk) disable iff (!rstn)
    ONE_CHAIN && st.mode == scfm_pkg::SCFM_MASK |=> unload_mask == '1)
    else $error("unload not masked");
  a_no_single: assert property (@(posedge ref_clk) disable iff (!rstn)
    !ONE_CHAIN |-> st.mode != scfm_pkg::SCFM_ONE)
    else $error("single mode without option");
endmodule : scfm_ctrl

// *** test/scfm_host.sv ***
// Upstream stream host: one payload bit per packet
module scfm_host (
  input wire logic ref_clk,
  input wire logic chan_in_ready,
  output logic chan_in,
  output logic chan_in_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    chan_in = 1'b0;
    chan_in_valid = 1'b0;
  end
  // Offer one bit, hold it until the edge that takes it
  task automatic send(input logic b);
    @(posedge ref_clk);
    chan_in <= b;
    chan_in_valid <= 1'b1;
    do @(posedge ref_clk); while (chan_in_ready !== 1'b1);
    chan_in_valid <= 1'b0;
    // Released line must not keep showing the old bit
    chan_in <= ~b;
  endtask : send
endmodule : scfm_host

// *** test/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rstn, reg_wr, reg_rd, shift_en, compact_out;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, rdata_a, rdata_b, decomp_in, chain_out;
  logic chan_in, chan_in_valid, chan_in_ready, out_a, out_b;
  logic [7:0] load_a, load_b, mask_a, mask_b;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  // Option built in
  scfm_ctrl #(.ONE_CHAIN(1'b1)) i_scfm_ctrl (.ref_clk, .rstn, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(rdata_a), .chan_in,
    .chan_in_valid, .chan_in_ready, .shift_en, .decomp_in, .compact_out,
    .chain_out, .chain_load(load_a), .unload_mask(mask_a), .chan_out(out_a));
  // Option left out; same stream, so its FIFO tracks the first
  scfm_ctrl #(.ONE_CHAIN(1'b0)) i_scfm_ctrl_b (.ref_clk, .rstn, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(rdata_b), .chan_in,
    .chan_in_valid, .chan_in_ready(), .shift_en, .decomp_in, .compact_out,
    .chain_out, .chain_load(load_b), .unload_mask(mask_b), .chan_out(out_b));
  scfm_host i_scfm_host (.ref_clk, .chan_in_ready, .chan_in, .chan_in_valid);
  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;
  task automatic end_sim();
    if (failures == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // Hang guard, far above the expected run length
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      end_sim();
    end
  end
  task automatic chk(input string what, input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    repeat (3) @(posedge ref_clk); // Write lands, then one output stage
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] da, db);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    da = rdata_a;
    db = rdata_b;
  endtask : rd
  // One payload bit, then one shift; loads seen right after
  task automatic pulse(input logic b);
    i_scfm_host.send(b);
    repeat (2) @(posedge ref_clk);
    shift_en <= 1'b1;
    @(posedge ref_clk);
    shift_en <= 1'b0;
    #1;
  endtask : pulse
  task automatic obs(input logic [7:0] tails);
    @(posedge ref_clk);
    chain_out <= tails;
    repeat (3) @(posedge ref_clk);
  endtask : obs
  task automatic t_reset();
    logic [7:0] a, b;
    rd(scfm_pkg::ADDR_MODE, a, b);
    chk("mode", a, 8'h01);
    chk("mode_b", b, 8'h02);
    rd(scfm_pkg::ADDR_INDEX, a, b);
    chk("index", a, 8'h00);
    rd(4'hA, a, b);
    chk("unmapped", a, 8'h00);
    rd(scfm_pkg::ADDR_STATUS, a, b);
    chk("status", a, 8'h05);
    chk("status_b", b, 8'h01);
  endtask : t_reset
  task automatic t_single();
    logic [7:0] a, b;
    wr(scfm_pkg::ADDR_INDEX, 8'h05);
    wr(scfm_pkg::ADDR_MODE, 8'h01);
    rd(scfm_pkg::ADDR_INDEX, a, b);
    chk("index5", a, 8'h05);
    rd(scfm_pkg::ADDR_MODE, a, b);
    chk("refused", b, 8'h02);
    pulse(1'b1);
    chk("load1", load_a, 8'h20);
    pulse(1'b0);
    chk("load0", load_a, 8'h00);
    obs(8'h20);
    chk("out5", {7'h00, out_a}, 8'h01);
    obs(8'hDF);
    chk("out5n", {7'h00, out_a}, 8'h00);
  endtask : t_single
  task automatic t_bcast();
    wr(scfm_pkg::ADDR_MODE, 8'h02);
    pulse(1'b1);
    chk("bc", load_a, 8'hFF);
    chk("bc_b", load_b, 8'hFF);
    obs(8'h20);
    chk("bc_out", {7'h00, out_a}, 8'h01);
    chk("bc_out_b", {7'h00, out_b}, 8'h00);
    obs(8'h01);
    chk("bc_out0", {7'h00, out_a}, 8'h00);
    chk("bc_out0_b", {7'h00, out_b}, 8'h01);
  endtask : t_bcast
  task automatic t_mask();
    wr(scfm_pkg::ADDR_MODE, 8'h03);
    chk("umask", mask_a, 8'hFF);
    chk("umask_b", mask_b, 8'h00);
    pulse(1'b1);
    chk("mload", load_a, 8'h00);
    chk("mload_b", load_b, 8'h00);
    compact_out <= 1'b1;
    obs(8'h00);
    chk("mout_b", {7'h00, out_b}, 8'h01);
  endtask : t_mask
  task automatic t_off();
    wr(scfm_pkg::ADDR_MODE, 8'h00);
    decomp_in <= 8'hA5;
    obs(8'hFF);
    chk("off_load", load_a, 8'hA5);
    chk("off_mask", mask_a, 8'h00);
    chk("off_out", {7'h00, out_a}, 8'h01);
    compact_out <= 1'b0;
    obs(8'hFF);
    chk("off_out0", {7'h00, out_a}, 8'h00);
  endtask : t_off
  // Fill until refused, then drain to empty
  task automatic t_fifo();
    logic [7:0] a, b;
    wr(scfm_pkg::ADDR_MODE, 8'h02);
    repeat (scfm_pkg::FIFO_DEPTH) i_scfm_host.send(1'b1);
    @(posedge ref_clk);
    chk("full_rdy", {7'h00, chan_in_ready}, 8'h00);
    rd(scfm_pkg::ADDR_STATUS, a, b);
    chk("full", a, 8'h06);
    @(posedge ref_clk);
    shift_en <= 1'b1;
    repeat (scfm_pkg::FIFO_DEPTH) @(posedge ref_clk);
    shift_en <= 1'b0;
    rd(scfm_pkg::ADDR_STATUS, a, b);
    chk("empty", a, 8'h05);
  endtask : t_fifo
  initial
  begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    shift_en = 1'b0;
    decomp_in = 8'h00;
    compact_out = 1'b0;
    chain_out = 8'h00;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset();
    t_single();
    t_bcast();
    t_mask();
    t_off();
    t_fifo();
    end_sim();
  end
endmodule : tb
